// ---- design/frmc_map.svh ----
// Constants for the flash read-margin command block
`ifndef FRMC_MAP_SVH
`define FRMC_MAP_SVH

// Command codes held in word index 000
`define FRMC_CMD_USER_MARGIN  8'h0D
`define FRMC_CMD_FIELD_MARGIN 8'h0E

// Word index values
`define FRMC_IDX_HEAD  3'h0
`define FRMC_IDX_LEVEL 3'h1

// Block codes in global address bits 17:16
`define FRMC_BLK_PFLASH 2'h0
`define FRMC_BLK_EEPROM 2'h1

// Margin level setting codes
`define FRMC_LVL_NORMAL    16'h0000
`define FRMC_LVL_USER_ERS  16'h0001
`define FRMC_LVL_USER_PGM  16'h0002
`define FRMC_LVL_FIELD_ERS 16'h0003
`define FRMC_LVL_FIELD_PGM 16'h0004

// Field positions within word 000
`define FRMC_HEAD_CMD_MSB 15
`define FRMC_HEAD_CMD_LSB 8
`define FRMC_HEAD_BLK_MSB 1
`define FRMC_HEAD_BLK_LSB 0

`endif

// ---- design/frmc_margin.sv ----
// Read-margin command sequencer for program flash and EEPROM
`timescale 1ns/1ps
`default_nettype none
`include "frmc_map.svh"

module frmc_margin
  import frmc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Command object writes
  input  wire logic        word_we_i,
  input  wire logic [2:0]  word_sel_i,
  input  wire logic [15:0] word_data_i,
  // Launch and status
  input  wire logic        launch_i,
  input  wire logic        special_mode_i,
  input  wire logic        err_clear_i,
  output logic             command_complete_flag_o,
  output logic             access_error_flag_o,
  output logic             protection_violation_flag_o,
  output logic [2:0]       command_word_index_o,
  // Margin levels presented to the arrays
  output var frmc_level_type pflash_read_level_o,
  output var frmc_level_type eeprom_read_level_o
);

  // Sequencer state and its next value
  frmc_state_type state;
  frmc_state_type next_state;

  // Loaded command object and last written index
  logic [15:0]    command_object_words [0:1];
  logic [2:0]     command_word_index;

  // Status flags and their next values
  logic           command_complete_flag;
  logic           next_complete_flag;
  logic           access_error_flag;
  logic           launch_err;
  logic           next_launch_err;

  // Recorded margin levels per block
  frmc_level_type pf_level;
  frmc_level_type ee_level;
  logic           ee_own;

  // Fields of the loaded command object
  wire logic [7:0]  cmd_code  = command_object_words[0][`FRMC_HEAD_CMD_MSB:`FRMC_HEAD_CMD_LSB];
  wire logic [1:0]  blk_code  = command_object_words[0][`FRMC_HEAD_BLK_MSB:`FRMC_HEAD_BLK_LSB];
  wire logic [15:0] lvl_code  = command_object_words[1];

  // Command identification
  wire logic        is_user   = (cmd_code == `FRMC_CMD_USER_MARGIN);
  wire logic        is_field  = (cmd_code == `FRMC_CMD_FIELD_MARGIN);
  wire logic        cmd_bad   = !(is_user || is_field);

  // Launch-time parameter checks
  wire logic        idx_bad   = (command_word_index != `FRMC_IDX_LEVEL);
  wire logic        mode_bad  = is_field && !special_mode_i;
  wire logic        blk_bad   = (blk_code != `FRMC_BLK_PFLASH)
                                && (blk_code != `FRMC_BLK_EEPROM);

  // Setting range per command
  wire logic        lvl_bad_u = (lvl_code > `FRMC_LVL_USER_PGM);
  wire logic        lvl_bad_f = (lvl_code > `FRMC_LVL_FIELD_PGM);
  wire logic        lvl_bad   = is_user ? lvl_bad_u : lvl_bad_f;

  // Any reason to refuse the command
  wire logic        any_bad   = cmd_bad || idx_bad || mode_bad || blk_bad || lvl_bad;

  // Launch accepted only when idle and complete
  wire logic        do_launch = launch_i && command_complete_flag && (state == FRMC_IDLE);

  // Execute cycle, split by outcome of the checks
  wire logic        exec_now  = (state == FRMC_EXEC);
  wire logic        exec_ok   = exec_now && !launch_err;
  wire logic        exec_err  = exec_now && launch_err;

  // Target block and per-block record strobes
  wire logic        to_ee     = (blk_code == `FRMC_BLK_EEPROM);
  wire logic        ee_rec    = exec_ok && to_ee;
  wire logic        pf_rec    = exec_ok && !to_ee;

  // These commands never raise a protection violation
  wire logic        pv_none   = 1'b0;

  // Setting code to level, range already checked
  wire frmc_level_type new_level =
    (lvl_code == `FRMC_LVL_USER_ERS)  ? FRMC_LEVEL_USER_ERS  :
    (lvl_code == `FRMC_LVL_USER_PGM)  ? FRMC_LEVEL_USER_PGM  :
    (lvl_code == `FRMC_LVL_FIELD_ERS) ? FRMC_LEVEL_FIELD_ERS :
    (lvl_code == `FRMC_LVL_FIELD_PGM) ? FRMC_LEVEL_FIELD_PGM :
                                        FRMC_LEVEL_NORMAL;

  // Write of command words, refused while busy
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      command_object_words[0] <= 16'h0000;
      command_object_words[1] <= 16'h0000;
    end else if (word_we_i && command_complete_flag) begin
      if (word_sel_i <= `FRMC_IDX_LEVEL) begin
        command_object_words[word_sel_i[0]] <= word_data_i;
      end
    end
  end

  // Index follows last written word
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      command_word_index <= 3'h0;
    end else if (word_we_i && command_complete_flag) begin
      command_word_index <= word_sel_i;
    end
  end

  // Next state and flags: launch, execute, complete
  always_comb begin
    next_state         = state;
    next_complete_flag = command_complete_flag;
    next_launch_err    = launch_err;
    unique case (state)
      FRMC_IDLE: begin
        if (do_launch) begin
          next_state         = FRMC_EXEC;
          next_complete_flag = 1'b0;
          next_launch_err    = any_bad;
        end
      end
      FRMC_EXEC: begin
        next_state = FRMC_DONE;
      end
      FRMC_DONE: begin
        next_state         = FRMC_IDLE;
        next_complete_flag = 1'b1;
      end
    endcase
  end

  // State and flag registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state                 <= FRMC_IDLE;
      command_complete_flag <= 1'b1;
      launch_err            <= 1'b0;
    end else begin
      state                 <= next_state;
      command_complete_flag <= next_complete_flag;
      launch_err            <= next_launch_err;
    end
  end

  // Sticky access error; a new error wins over a clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      access_error_flag <= 1'b0;
    end else if (exec_err) begin
      access_error_flag <= 1'b1;
    end else if (err_clear_i) begin
      access_error_flag <= 1'b0;
    end
  end

  // Program flash level, also seen by EEPROM when not owned
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pf_level <= FRMC_LEVEL_NORMAL;
    end else if (pf_rec) begin
      pf_level <= new_level;
    end
  end

  // EEPROM own level
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ee_level <= FRMC_LEVEL_NORMAL;
    end else if (ee_rec) begin
      ee_level <= new_level;
    end
  end

  // EEPROM ownership: taken by EEPROM target, dropped by flash target
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ee_own <= 1'b0;
    end else if (ee_rec) begin
      ee_own <= 1'b1;
    end else if (pf_rec) begin
      ee_own <= 1'b0;
    end
  end

  // Level seen by each array
  assign pflash_read_level_o         = pf_level;
  assign eeprom_read_level_o         = ee_own ? ee_level : pf_level;

  // Status outputs
  assign command_complete_flag_o     = command_complete_flag;
  assign access_error_flag_o         = access_error_flag;
  assign protection_violation_flag_o = pv_none;
  assign command_word_index_o        = command_word_index;

endmodule
`default_nettype wire

// ---- design/frmc_pkg.sv ----
// Types for the flash read-margin command block
package frmc_pkg;
  typedef enum logic [2:0] {
    FRMC_LEVEL_NORMAL,
    FRMC_LEVEL_USER_ERS,
    FRMC_LEVEL_USER_PGM,
    FRMC_LEVEL_FIELD_ERS,
    FRMC_LEVEL_FIELD_PGM
  } frmc_level_type;

  typedef enum logic [1:0] {
    FRMC_IDLE,
    FRMC_EXEC,
    FRMC_DONE
  } frmc_state_type;
endpackage

// ---- testbench/frmc_array_model.sv ----
// Array model: read word flags a margin read
`timescale 1ns/1ps
`default_nettype none
module frmc_array_model
  import frmc_pkg::*;
(
  // Clock, levels in, read words out
  input  wire logic           clk_i,
  input  wire frmc_level_type pf_lvl_i, ee_lvl_i,
  output logic [15:0]         pf_rd_o, ee_rd_o
);
  // Low bit shows a margin sense level
  always_ff @(posedge clk_i) begin
    pf_rd_o <= {15'h52A5, pf_lvl_i != FRMC_LEVEL_NORMAL};
    ee_rd_o <= {15'h52A5, ee_lvl_i != FRMC_LEVEL_NORMAL};
  end
endmodule
`default_nettype wire

// ---- testbench/frmc_margin_asserts.sv ----
// Assertions on the read-margin sequencer ports
`timescale 1ns/1ps
`default_nettype none
module frmc_margin_asserts
  import frmc_pkg::*;
(
  // Watched ports
  input wire logic           clk_i, arst_n_i, word_we_i, launch_i, special_mode_i,
  input wire logic [2:0]     word_sel_i, command_word_index_o,
  input wire logic [15:0]    word_data_i,
  input wire logic           command_complete_flag_o, access_error_flag_o,
  input wire logic           protection_violation_flag_o,
  input wire frmc_level_type pflash_read_level_o, eeprom_read_level_o
);
  // Short names and last command code
  wire cf = command_complete_flag_o;
  wire er = access_error_flag_o;
  wire go = launch_i && cf;
  logic [7:0] code;
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i) code <= 8'h00;
    else if (word_we_i && cf && word_sel_i == 3'h0) code <= word_data_i[15:8];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Busy two cycles, then complete
  sequence s_run; !cf ##1 !cf ##1 cf; endsequence
  property p_run; go |=> s_run; endproperty
  a_run: assert property (p_run) else $error("run length wrong");
  property p_idx; go && command_word_index_o != 3'h1 |-> ##2 er; endproperty
  a_idx: assert property (p_idx) else $error("index error missing");
  property p_mode; go && code == 8'h0E && !special_mode_i |-> ##2 er; endproperty
  a_mode: assert property (p_mode) else $error("mode error missing");
  property p_err; $rose(er) |-> !cf; endproperty
  a_err: assert property (p_err) else $error("error while idle");
  property p_pv; !protection_violation_flag_o; endproperty
  a_pv: assert property (p_pv) else $error("protection flag set");
  property p_pf; $changed(pflash_read_level_o) |-> eeprom_read_level_o == pflash_read_level_o;
  endproperty
  a_pf: assert property (p_pf) else $error("eeprom not following");
  property p_hold;
    $changed({pflash_read_level_o, eeprom_read_level_o}) |-> !cf && !$rose(er);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved");
  property p_sel; word_we_i && cf |=> command_word_index_o == $past(word_sel_i); endproperty
  a_sel: assert property (p_sel) else $error("index not kept");
endmodule
`default_nettype wire

// ---- testbench/tb_frmc_margin.sv ----
// Self-checking bench for the read-margin sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_frmc_margin;
  import frmc_pkg::*;
  logic clk_i = 0, arst_n_i = 0, we = 0, go = 0, sp = 0, ec = 0, e_er = 0, lf = 1;
  logic cf, er, pv;
  logic [2:0] sel = 0, ix;
  logic [15:0] prd, erd;
  logic [15:0] d = 0;
  frmc_level_type pf, ee, e_pf = FRMC_LEVEL_NORMAL, e_ee = FRMC_LEVEL_NORMAL;
  logic [6:0] q[$];
  int fail_count = 0, total_checks = 0, seed = 5, i, n;
  always #10 clk_i = ~clk_i;
  frmc_margin i_dut (.clk_i, .arst_n_i, .word_we_i(we), .word_sel_i(sel),
    .word_data_i(d), .launch_i(go), .special_mode_i(sp), .err_clear_i(ec),
    .command_complete_flag_o(cf), .access_error_flag_o(er),
    .protection_violation_flag_o(pv), .command_word_index_o(ix),
    .pflash_read_level_o(pf), .eeprom_read_level_o(ee));
  frmc_array_model i_arr (.clk_i, .pf_lvl_i(pf), .ee_lvl_i(ee), .pf_rd_o(prd), .ee_rd_o(erd));
  task automatic chk(input string s, input logic [6:0] x, input logic [6:0] g);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Oldest note against each completed command
  always @(posedge clk_i) begin
    #1;
    if (cf === 1'b1 && lf === 1'b0)
      chk("result", q.pop_front(), {er, pf, ee});
    lf = cf;
  end
  // Write word 0 and word x, launch, note expectation, wait
  task automatic cmd(input logic [7:0] c, input logic [1:0] b, input logic [2:0] l, x);
    logic v;
    v = x == 3'h1 && b < 2'h2 && (c == 8'h0D && l < 3'h3 || c == 8'h0E && sp && l < 3'h5);
    we = 1;
    sel = 0;
    d = {c, 6'h00, b};
    @(posedge clk_i); #2 sel = x;
    d = {13'h0000, l};
    @(posedge clk_i); #2 we = 0;
    go = 1;
    @(posedge clk_i); #2 go = 0;
    if (v) e_ee = frmc_level_type'(l);
    if (v && b == 2'h0) e_pf = e_ee;
    e_er = e_er | !v;
    q.push_back({e_er, e_pf, e_ee});
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i); #2;
      if (cf === 1'b1 && n > 1) break;
    end
    if (n == 20) begin
      fail_count++;
      end_sim();
    end
    chk("index", 7'(x), 7'(ix));
    chk("pf read", 7'(e_pf != FRMC_LEVEL_NORMAL), 7'(prd[0]));
    chk("ee read", 7'(e_ee != FRMC_LEVEL_NORMAL), 7'(erd[0]));
    chk("protect", 7'h00, 7'(pv));
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #2 arst_n_i = 1;
    // Field codes on both blocks, as factory verify would
    sp = 1;
    for (i = 0; i < 10; i++) cmd(8'h0E, 2'(i % 2), 3'(i / 2), 3'h1);
    $display("test field codes done");
    // Random codes, modes, blocks, levels, indexes and clears
    for (i = 0; i < 60; i++) begin
      sp = 1'($random(seed));
      if (i % 9 == 0) begin
        ec = 1;
        @(posedge clk_i); #2 ec = 0;
        e_er = 0;
      end
      cmd(8'h0D + 8'({$random(seed)} % 3), 2'({$random(seed)} % 4),
        3'({$random(seed)} % 6), (i % 11) ? 3'h1 : 3'h2);
    end
    $display("test random done");
    // Reset restores normal reads
    arst_n_i = 0;
    #5 chk("reset", 7'h00, {er, pf, ee});
    @(posedge clk_i); #2 arst_n_i = 1;
    e_er = 0;
    e_pf = FRMC_LEVEL_NORMAL;
    e_ee = FRMC_LEVEL_NORMAL;
    cmd(8'h0D, 2'h0, 3'h2, 3'h1);
    $display("test reset done");
    end_sim();
  end
endmodule
bind frmc_margin frmc_margin_asserts i_chk (.*);
`default_nettype wire
